// >>> iosi_top.sv
/*
  status indicator block for an eight-channel output block:
  drives the channel outputs, the channel lamps, two bus lamps
  and two block lamps, and offers a small register port with
  an interrupt.
  assumes bus_state and block_state come from logic on clk;
  bus_power and chan_fault come from pins and are synchronised.
  assumes the register master never raises both strobes at once;
  a low ce freezes every flip-flop, strobes included.
*/
`timescale 1ns/1ps
module iosi_top
  import iosi_pkg::*;
#(
  parameter int TICK_CYCLES = IOSI_TICK_CYCLES  // prescaler length
) (
  input  wire  logic        clk,
  input  wire  logic        nrst,
  input  wire  logic        ce,
  // register port
  input  wire  logic [7:0]  addr,
  input  wire  logic [31:0] wr_data,
  input  wire  logic        wr_stb,
  input  wire  logic        rd_stb,
  output logic       [31:0] rd_data,
  output logic              irq,
  // state inputs
  input  wire  logic        bus_power,
  input  wire  logic [1:0]  bus_state,
  input  wire  logic [1:0]  block_state,
  input  wire  logic [7:0]  chan_fault,
  // outputs and lamps
  output logic       [7:0]  output_channel,
  output logic       [7:0]  chan_lamp,
  output logic              bus_lamp_green,
  output logic              bus_lamp_red,
  output logic              blk_lamp_green,
  output logic              blk_lamp_red
);

  // flash pattern levels, shared by both block lamps so
  // green and red flash in step
  iosi_flash_if fl ();

  // pin synchronisers, first stage read only by second
  logic       pwr_s1_reg;   // power first stage
  logic       pwr_s2_reg;   // power stable
  logic [7:0] flt_s1_reg;   // fault first stage
  logic [7:0] flt_s2_reg;   // fault stable

  // software visible state
  logic [7:0]            out_reg;       // channel commands
  logic [7:0]            out_next;      // next commands
  logic [IOSI_IRQ_W-1:0] irq_stat_reg;  // sticky events
  logic [IOSI_IRQ_W-1:0] irq_stat_next; // next sticky events
  logic [IOSI_IRQ_W-1:0] irq_mask_reg;  // interrupt enables
  logic [31:0]           rd_data_reg;   // read answer
  logic [31:0]           rd_data_next;  // read answer next
  logic                  irq_reg;       // interrupt output

  // lamp state
  logic [7:0] ch_lamp_reg;   // channel lamps
  logic [7:0] ch_out_reg;    // channel output drivers
  logic       bus_g_reg;     // bus green
  logic       bus_r_reg;     // bus red
  logic       blk_g_reg;     // block green
  logic       blk_r_reg;     // block red
  logic       bus_g_next;    // bus green next
  logic       bus_r_next;    // bus red next
  logic       blk_g_next;    // block green next
  logic       blk_r_next;    // block red next

  // event detection
  iosi_bus_t             bus_st;        // decoded bus state
  iosi_blk_t             blk_st;        // decoded block state
  logic                  any_fault;     // any channel faulted
  logic                  any_fault_reg; // previous fault level
  logic                  bus_err_reg;   // previous bus error level
  logic                  bus_op_reg;    // previous bus op level
  logic                  blk_err_reg;   // previous block error
  logic [IOSI_IRQ_W-1:0] events;        // this cycle's events
  logic                  stat_rd;       // status read clears

  // flash generator
  iosi_flash_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_flash (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .fl   (fl.gen)
  );

  // decode the state inputs
  // code 3 of the bus state is shown as an error
  assign bus_st    = iosi_bus_t'(bus_state);
  assign blk_st    = iosi_blk_t'(block_state);
  assign any_fault = |flt_s2_reg;

  // two-flop synchronisers for pin inputs
  // (metastability guard; costs two cycles of lamp latency)
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwr_s1_reg <= 1'b0;
      pwr_s2_reg <= 1'b0;
      flt_s1_reg <= 8'h00;
      flt_s2_reg <= 8'h00;
    end else if (ce) begin
      pwr_s1_reg <= bus_power;
      pwr_s2_reg <= pwr_s1_reg;
      flt_s1_reg <= chan_fault;
      flt_s2_reg <= flt_s1_reg;
    end
  end

  // channel command register write
  // unmapped writes and read strobes leave the commands alone
  always_comb begin
    out_next = out_reg;
    if (wr_stb && addr == IOSI_OFS_OUT) begin
      out_next = wr_data[7:0];
    end
  end

  // channel command register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_reg <= IOSI_OUT_RST;
    end else if (ce) begin
      out_reg <= out_next;
    end
  end

  // interrupt mask register
  // an event already pending raises irq one cycle after the mask register takes the write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_mask_reg <= IOSI_MASK_RST;
    end else if (ce && wr_stb && addr == IOSI_OFS_IRQ_MASK) begin
      irq_mask_reg <= wr_data[IOSI_IRQ_W-1:0];
    end
  end

  // channel drivers and lamps from the same next value,
  // so a lamp never disagrees with its output,
  // both written with the command, no extra cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ch_out_reg  <= IOSI_OUT_RST;
      ch_lamp_reg <= IOSI_OUT_RST;
    end else if (ce) begin
      // bit OUTPUT_CHANNEL_FIRST is connector 1
      ch_out_reg  <= out_next;
      ch_lamp_reg <= out_next;
    end
  end

  // bus lamps from bus power and bus state
  // registered so a state change shows one cycle later,
  // never as a glitch on the lamp driver
  always_comb begin
    bus_g_next = 1'b0;
    bus_r_next = 1'b0;
    if (!pwr_s2_reg) begin
      // no bus power: both dark
      bus_g_next = 1'b0;
      bus_r_next = 1'b0;
    end else begin
      unique case (bus_st)
        // powered, not initialised
        BUS_PREOP: begin
          bus_g_next = 1'b1;
          bus_r_next = 1'b1;
        end
        // operational
        BUS_OP: begin
          bus_g_next = 1'b1;
          bus_r_next = 1'b0;
        end
        // bus error detected
        BUS_ERR: begin
          bus_g_next = 1'b0;
          bus_r_next = 1'b1;
        end
        // unused code shown as an error
        default: begin
          bus_g_next = 1'b0;
          bus_r_next = 1'b1;
        end
      endcase
    end
  end

  // green block lamp from the block state
  // block lamps ignore bus power by design
  always_comb begin
    blk_g_next = 1'b0;
    unique case (blk_st)
      // reset: single flash
      BLK_RESET: blk_g_next = fl.single;
      // preoperational: continuous blink
      BLK_PREOP: blk_g_next = fl.blink;
      // operational: steady
      BLK_OP:    blk_g_next = 1'b1;
      // error: green dark
      BLK_ERR:   blk_g_next = 1'b0;
    endcase
  end

  // red block lamp, channel fault pattern takes precedence
  // a faulted channel hides a block error behind the single
  // flash; the status register still tells the two apart
  always_comb begin
    blk_r_next = 1'b0;
    if (any_fault) begin
      // channel fault: single flash
      blk_r_next = fl.single;
    end else if (blk_st == BLK_ERR || blk_st == BLK_RESET) begin
      // error or reset: steady on
      blk_r_next = 1'b1;
    end else begin
      // ok: dark
      blk_r_next = 1'b0;
    end
  end

  // lamp flip-flops
  // all four frozen together while ce is low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus_g_reg <= 1'b0;
      bus_r_reg <= 1'b0;
      blk_g_reg <= 1'b0;
      blk_r_reg <= 1'b0;
    end else if (ce) begin
      bus_g_reg <= bus_g_next;
      bus_r_reg <= bus_r_next;
      blk_g_reg <= blk_g_next;
      blk_r_reg <= blk_r_next;
    end
  end

  // previous levels for rising edge events
  // cleared by reset so a condition already true at release
  // still counts as entered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      any_fault_reg <= 1'b0;
      bus_err_reg   <= 1'b0;
      bus_op_reg    <= 1'b0;
      blk_err_reg   <= 1'b0;
    end else if (ce) begin
      any_fault_reg <= any_fault;
      bus_err_reg   <= pwr_s2_reg && bus_st == BUS_ERR;
      bus_op_reg    <= pwr_s2_reg && bus_st == BUS_OP;
      blk_err_reg   <= blk_st == BLK_ERR;
    end
  end

  // events: entry into each watched condition
  // one cycle per entry; a held condition does not repeat
  always_comb begin
    events = '0;
    events[IOSI_IRQ_BUS_ERR]  = pwr_s2_reg && bus_st == BUS_ERR && !bus_err_reg;
    events[IOSI_IRQ_BLK_ERR]  = blk_st == BLK_ERR && !blk_err_reg;
    events[IOSI_IRQ_CH_FAULT] = any_fault && !any_fault_reg;
    events[IOSI_IRQ_BUS_OP]   = pwr_s2_reg && bus_st == BUS_OP && !bus_op_reg;
  end

  // sticky status, cleared by a read, a new event wins
  // the event is or-ed in after the clear so an entry landing
  // in the very cycle of the read is kept for the next read
  // rather than lost
  assign stat_rd = rd_stb && addr == IOSI_OFS_IRQ_STAT;
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (stat_rd) begin
      irq_stat_next = '0;
    end
    irq_stat_next = irq_stat_next | events;
  end

  // sticky status and interrupt level
  // irq uses the next status so it moves with the status bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_stat_reg <= '0;
      irq_reg      <= 1'b0;
    end else if (ce) begin
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // read mux, zero outside the read cycle and off the map
  // status reads show raw state inputs but synchronised pins,
  // so a pin change appears two cycles late
  always_comb begin
    rd_data_next = 32'h0;
    if (rd_stb) begin
      unique case (addr)
        // channel commands
        IOSI_OFS_OUT: rd_data_next[7:0] = out_reg;
        // live state and lamps
        IOSI_OFS_STATUS: begin
          rd_data_next[IOSI_ST_BUS_LSB +: 2] = bus_state;
          rd_data_next[IOSI_ST_BLK_LSB +: 2] = block_state;
          rd_data_next[IOSI_ST_POWER]        = pwr_s2_reg;
          rd_data_next[IOSI_ST_FAULT]        = any_fault;
          rd_data_next[IOSI_ST_FLT_LSB +: 8] = flt_s2_reg;
          rd_data_next[IOSI_ST_LAMP_LSB +: 4] =
            {blk_r_reg, blk_g_reg, bus_r_reg, bus_g_reg};
        end
        // sticky events
        IOSI_OFS_IRQ_STAT: rd_data_next[IOSI_IRQ_W-1:0] = irq_stat_reg;
        // enables
        IOSI_OFS_IRQ_MASK: rd_data_next[IOSI_IRQ_W-1:0] = irq_mask_reg;
        // unmapped reads zero
        default: rd_data_next = 32'h0;
      endcase
    end
  end

  // read data register
  // answer stands one cycle, then falls back to zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_data_reg <= 32'h0;
    end else if (ce) begin
      rd_data_reg <= rd_data_next;
    end
  end

  // outputs straight from flip-flops
  // no logic between these flip-flops and the pins
  assign rd_data        = rd_data_reg;
  assign irq            = irq_reg;
  assign output_channel = ch_out_reg;
  assign chan_lamp      = ch_lamp_reg;
  assign bus_lamp_green = bus_g_reg;
  assign bus_lamp_red   = bus_r_reg;
  assign blk_lamp_green = blk_g_reg;
  assign blk_lamp_red   = blk_r_reg;

endmodule : iosi_top

// >>> iosi_pkg.sv
/*
  constants and types shared by the status indicator block:
  register offsets, field positions, reset values, state encodings
  and flash timing.
  assumes a 125 mhz system clock and a 32-bit plain register port.
*/
// How it works
// - bus powered, uninitialised: both bus lamps lit
// - bus operational: green lit, red dark
// - bus error: green dark, red lit
// - channel lamp lit exactly while output active
// - eight channels, connector n drives channel n-1
// - green block lamp: single flash, flashing, steady
// - red block lamp lit on error or reset
// - channel fault: red block lamp single flashes
package iosi_pkg;

  // register byte offsets
  localparam logic [7:0] IOSI_OFS_OUT      = 8'h00;
  localparam logic [7:0] IOSI_OFS_STATUS   = 8'h04;
  localparam logic [7:0] IOSI_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] IOSI_OFS_IRQ_MASK = 8'h0c;

  // channel numbering, connector n maps to channel n-1
  localparam int IOSI_NUM_CH              = 8;
  localparam int OUTPUT_CHANNEL_FIRST     = 0;
  localparam int OUTPUT_CHANNEL_LAST      = 7;

  // status register field positions
  localparam int IOSI_ST_BUS_LSB   = 0;
  localparam int IOSI_ST_BLK_LSB   = 2;
  localparam int IOSI_ST_POWER     = 4;
  localparam int IOSI_ST_FAULT     = 5;
  localparam int IOSI_ST_FLT_LSB   = 8;
  localparam int IOSI_ST_LAMP_LSB  = 16;

  // interrupt status bit positions
  localparam int IOSI_IRQ_BUS_ERR  = 0;
  localparam int IOSI_IRQ_BLK_ERR  = 1;
  localparam int IOSI_IRQ_CH_FAULT = 2;
  localparam int IOSI_IRQ_BUS_OP   = 3;
  localparam int IOSI_IRQ_W        = 4;

  // reset values
  localparam logic [7:0]          IOSI_OUT_RST  = 8'h00;
  localparam logic [IOSI_IRQ_W-1:0] IOSI_MASK_RST = 4'h0;

  // flash timing: tick period and pattern lengths in ticks
  localparam int IOSI_CLK_MHZ         = 125;
  localparam int IOSI_TICK_US         = 1000;
  localparam int IOSI_TICK_CYCLES     = IOSI_TICK_US * IOSI_CLK_MHZ;
  localparam int IOSI_BLINK_TICKS     = 200;
  localparam int IOSI_SINGLE_ON_TICKS = 200;
  localparam int IOSI_SINGLE_PER_TICKS = 1000;

  // bus and block states as seen on the state inputs
  typedef enum logic [1:0] {BUS_PREOP, BUS_OP, BUS_ERR, BUS_RSVD} iosi_bus_t;
  typedef enum logic [1:0] {BLK_RESET, BLK_PREOP, BLK_OP, BLK_ERR} iosi_blk_t;

endpackage : iosi_pkg

// >>> iosi_flash_if.sv
/*
  interface carrying flash pattern levels from the generator
  to the lamp logic.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface iosi_flash_if;
  logic blink;   // symmetric blink level
  logic single;  // one short pulse per repeat period

  // generator end
  modport gen (output blink, output single);
  // lamp logic end
  modport sink (input blink, input single);
endinterface : iosi_flash_if

// >>> iosi_flash_gen.sv
/*
  flash pattern generator: prescaler, symmetric blink and single flash.
  assumes clk, synchronous active-low nrst and a clock enable.
*/
`timescale 1ns/1ps
module iosi_flash_gen
  import iosi_pkg::*;
#(
  parameter int TICK_CYCLES = IOSI_TICK_CYCLES
) (
  input  wire logic  clk,
  input  wire logic  nrst,
  input  wire logic  ce,
  iosi_flash_if.gen  fl
);
  logic [31:0] pre_reg;    // prescaler count
  logic [15:0] blk_reg;    // blink tick count
  logic [15:0] sgl_reg;    // single flash tick count
  logic        tick_reg;   // prescaler pulse
  logic        blink_reg;  // blink level

  // prescaler makes one tick every TICK_CYCLES
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end else if (ce) begin
      tick_reg <= (pre_reg == 32'(TICK_CYCLES - 1));
      if (pre_reg == 32'(TICK_CYCLES - 1)) pre_reg <= 32'h0;
      else pre_reg <= pre_reg + 32'h1;
    end
  end

  // symmetric blink: toggle every half period
  always_ff @(posedge clk) begin
    if (!nrst) begin
      blk_reg   <= 16'h0;
      blink_reg <= 1'b0;
    end else if (ce && tick_reg) begin
      if (blk_reg == 16'(IOSI_BLINK_TICKS - 1)) begin
        blk_reg   <= 16'h0;
        blink_reg <= ~blink_reg;
      end else begin
        blk_reg <= blk_reg + 16'h1;
      end
    end
  end

  // single flash: repeat period counter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sgl_reg <= 16'h0;
    end else if (ce && tick_reg) begin
      if (sgl_reg == 16'(IOSI_SINGLE_PER_TICKS - 1)) sgl_reg <= 16'h0;
      else sgl_reg <= sgl_reg + 16'h1;
    end
  end

  assign fl.blink  = blink_reg;
  assign fl.single = (sgl_reg < 16'(IOSI_SINGLE_ON_TICKS));
endmodule : iosi_flash_gen

// >>> iosi_state_model.sv
/* far-side model: bus state logic and pins feeding the indicator block.
   assumes one clock; the bench gives wanted values, we launch them
   just after a rising edge as real upstream logic would. */
`timescale 1ns/1ps
module iosi_state_model (
  input  wire logic       clk,
  input  wire logic       want_power,  // bus power wanted
  input  wire logic [1:0] want_bus,    // bus state wanted
  input  wire logic [1:0] want_blk,    // block state wanted
  input  wire logic [7:0] want_fault,  // channel faults wanted
  output logic            bus_power,   // to power pin
  output logic      [1:0] bus_state,   // to bus state input
  output logic      [1:0] block_state, // to block state input
  output logic      [7:0] chan_fault   // to fault pins
);
  // quiet, unpowered start
  initial begin
    bus_power   = 1'b0;
    bus_state   = 2'h0;
    block_state = 2'h0;
    chan_fault  = 8'h00;
  end
  // registered launch, one cycle after request
  always @(posedge clk) begin
    bus_power   <= want_power;
    bus_state   <= want_bus;
    block_state <= want_blk;
    chan_fault  <= want_fault;
  end
endmodule : iosi_state_model

// >>> iosi_top_sva.sv
/* checker of lamp and output relations at the top ports.
   assumes one clock; writes count only with ce high; pins settle in 3 cycles. */
`timescale 1ns/1ps
module iosi_top_chk
  import iosi_pkg::*;
#(parameter int TICK_CYCLES = 4) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic       irq,
  input wire logic       bus_power,
  input wire logic [1:0] bus_state,
  input wire logic [1:0] block_state,
  input wire logic [7:0] chan_fault,
  input wire logic [7:0] output_channel,
  input wire logic [7:0] chan_lamp,
  input wire logic       bus_lamp_green,
  input wire logic       bus_lamp_red,
  input wire logic       blk_lamp_green,
  input wire logic       blk_lamp_red
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chan_follow_a: assert property (chan_lamp == output_channel)
    else $error("channel lamp differs from output");
  out_write_a: assert property (ce && wr_stb && addr == 8'h00 |=>
    output_channel == $past(wr_data[7:0])) else $error("output write lost");
  power_off_a: assert property (!bus_power [*4] |=>
    !bus_lamp_green && !bus_lamp_red) else $error("bus lamp lit unpowered");
  bus_preop_a: assert property (bus_power [*4] ##0 bus_state == 2'h0 |=>
    bus_lamp_green && bus_lamp_red) else $error("preop bus lamps wrong");
  bus_op_a: assert property (bus_power [*4] ##0 bus_state == 2'h1 |=>
    bus_lamp_green && !bus_lamp_red) else $error("op bus lamps wrong");
  bus_err_a: assert property (bus_power [*4] ##0 bus_state[1] |=>
    !bus_lamp_green && bus_lamp_red) else $error("error bus lamps wrong");
  blk_op_a: assert property (block_state == 2'h2 |=> blk_lamp_green)
    else $error("op block lamp dark");
  blk_red_a: assert property ((chan_fault == 8'h00) [*4] |=> blk_lamp_red ==
    ($past(block_state) == 2'h3 || $past(block_state) == 2'h0))
    else $error("red block lamp wrong");
  // main scenarios reached
  irq_c: cover property ($rose(irq));
  blink_c: cover property (block_state == 2'h1 ##1 $fell(blk_lamp_green));
  fault_c: cover property (chan_fault != 8'h00 ##1 $rose(blk_lamp_red));
  read_c: cover property (rd_stb);
endmodule : iosi_top_chk
bind iosi_top iosi_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_iosi_top_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .irq(irq), .bus_power(bus_power), .bus_state(bus_state),
  .block_state(block_state), .chan_fault(chan_fault),
  .output_channel(output_channel), .chan_lamp(chan_lamp),
  .bus_lamp_green(bus_lamp_green), .bus_lamp_red(bus_lamp_red),
  .blk_lamp_green(blk_lamp_green), .blk_lamp_red(blk_lamp_red));

// >>> tb_top.sv
/* self-checking bench for the status indicator block.
   assumes a short prescaler (4 cycles a tick); ce high outside t_ce. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import iosi_pkg::*;
  localparam int TK = 4;                 // cycles per tick
  localparam int WIN = 2 * IOSI_SINGLE_PER_TICKS * TK; // count window
  logic        clk, nrst, ce, wr_stb, rd_stb, irq, pw, bg, br, kg, kr, w_pow;
  logic [7:0]  addr, flt, och, clamp, w_flt;
  logic [31:0] wr_data, rd_data, d;
  logic [1:0]  bst, kst, w_bus, w_blk;
  int          n_mismatch, n_checks, g, r;
  int          eg[4] = '{2 * IOSI_SINGLE_ON_TICKS * TK, WIN / 2, WIN, 0};
  int          er[4] = '{WIN, 0, 0, WIN};
  iosi_top #(.TICK_CYCLES(TK)) u_iosi_top (.clk(clk), .nrst(nrst), .ce(ce),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .irq(irq), .bus_power(pw), .bus_state(bst),
    .block_state(kst), .chan_fault(flt), .output_channel(och),
    .chan_lamp(clamp), .bus_lamp_green(bg), .bus_lamp_red(br),
    .blk_lamp_green(kg), .blk_lamp_red(kr));
  iosi_state_model u_iosi_state_model (.clk(clk), .want_power(w_pow),
    .want_bus(w_bus), .want_blk(w_blk), .want_fault(w_flt), .bus_power(pw),
    .bus_state(bst), .block_state(kst), .chan_fault(flt));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // bus cycles and helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a; wr_data <= v; wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task automatic want(input logic p, input logic [1:0] b, k, input logic [7:0] f);
    @(posedge clk);
    w_pow <= p; w_bus <= b; w_blk <= k; w_flt <= f;
    repeat (6) @(posedge clk);
    #1;
  endtask : want
  task automatic cnt();
    g = 0; r = 0;
    repeat (WIN) begin
      @(posedge clk);
      #1 g += (kg === 1'b1); r += (kr === 1'b1);
    end
  endtask : cnt
  // reset values, unmapped place refused
  task automatic t_regs();
    rd(8'h00); `CHK("out reset", 32'h0, d)
    rd(8'h0c); `CHK("mask reset", 32'h0, d)
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10); `CHK("unmapped", 32'h0, d)
  endtask : t_regs
  // walking one over all channels
  task automatic t_out();
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 32'h1 << i);
      `CHK("output", 8'h01 << i, och)
      `CHK("chan lamp", 8'h01 << i, clamp)
    end
  endtask : t_out
  // clock enable low freezes state, strobes ignored
  task automatic t_ce();
    wr(8'h00, 32'h5a);
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h00, 32'ha5);
    `CHK("frozen out", 8'h5a, och)
    @(posedge clk);
    ce <= 1'b1;
    rd(8'h00);
    `CHK("thawed out", 32'h5a, d)
  endtask : t_ce
  // bus lamp table, power off and every state
  task automatic t_bus();
    logic [1:0] exp[5] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h1};
    for (int i = 0; i < 5; i++) begin
      want(i != 0, 2'(i == 0 ? 0 : i - 1), 2'h2, 8'h00);
      `CHK("bus lamps", exp[i], {bg, br})
    end
  endtask : t_bus
  // block lamp patterns counted over two single periods
  task automatic t_blk();
    for (int k = 0; k < 4; k++) begin
      want(1'b1, 2'h1, 2'(k), 8'h00);
      cnt();
      `CHK("blk green", eg[k], g)
      `CHK("blk red", er[k], r)
    end
    want(1'b1, 2'h1, 2'h3, 8'h80);
    cnt();
    `CHK("fault red", 2 * IOSI_SINGLE_ON_TICKS * TK, r)
  endtask : t_blk
  // error event raises irq, read clears, mask hides
  task automatic t_irq();
    logic [31:0] st;  // expected status word
    want(1'b1, 2'h1, 2'h2, 8'h00);
    wr(8'h0c, 32'h1);
    rd(8'h08);
    want(1'b1, 2'h2, 2'h2, 8'h00);
    `CHK("irq set", 1'b1, irq)
    rd(8'h08); `CHK("irq stat", 4'h1, d[3:0])
    `CHK("irq clear", 1'b0, irq)
    wr(8'h0c, 32'h0);
    want(1'b1, 2'h1, 2'h2, 8'h00);
    want(1'b1, 2'h2, 2'h2, 8'h00);
    `CHK("irq masked", 1'b0, irq)
    rd(8'h08); `CHK("masked stat", 4'h9, d[3:0])
    // powered, bus error, block operational, no fault
    st = (32'h2 << IOSI_ST_BUS_LSB) | (32'h2 << IOSI_ST_BLK_LSB) | (32'h1 << IOSI_ST_POWER);
    // lamps {blk red, blk green, bus red, bus green} = 0110
    st |= 32'h6 << IOSI_ST_LAMP_LSB;
    rd(8'h04);
    `CHK("status", st, d)
  endtask : t_irq
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // watchdog well past the expected run
  initial begin
    #800000;
    n_mismatch++;
    finish_test();
  end
  // main sequence
  initial begin
    nrst = 1'b0; ce = 1'b1; addr = 8'h00; wr_data = 32'h0;
    wr_stb = 1'b0; rd_stb = 1'b0; w_pow = 1'b0; w_bus = 2'h0;
    w_blk = 2'h0; w_flt = 8'h00; n_mismatch = 0; n_checks = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_out();
    t_ce();
    t_bus();
    t_blk();
    t_irq();
    finish_test();
  end
endmodule : tb_top
